//--- verilog/eth_tx_mac_end.sv
// mac end: accepts the tx word stream, checks framing, injects errors, forwards words
//
// Operation
// - client sends big-endian, top word in [255:192]
// - client never sends frames under nine bytes
// - packets start only at a word's top byte
// - start flag bit zero means lowest word
// - end flag marks word holding last byte
// - empty slice valid only where end flag set
// - idle flags mark words without frame data
// - accept output means this cycle's beat taken
// - error flag in end cycle corrupts packet
// - corrupted packet reads as malformed at receiver
// - all signals timed by mac-supplied clock
// - mac clock runs at 390.625 MHz (here clk_txmac is CORE_CLK passed through, run at 100 MHz on the bench)
// - client sends packet words with no gaps
`timescale 1ns/1ps
module eth_tx_mac_end (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    eth_tx_stream_if.mac bus,
    input wire logic DRAIN_READY,
    output logic OUT_VALID,
    output logic [eth_tx_stream_pkg::BUS_W-1:0] OUT_DATA,
    output logic [eth_tx_stream_pkg::LANES-1:0] OUT_SOP,
    output logic [eth_tx_stream_pkg::LANES-1:0] OUT_EOP,
    output logic [eth_tx_stream_pkg::EMPTY_BUS_W-1:0] OUT_EMPTY,
    output logic [eth_tx_stream_pkg::LANES-1:0] OUT_DATA_WORD,
    output logic [eth_tx_stream_pkg::LANES-1:0] OUT_BAD,
    output logic GAP_ERR,
    output logic SOP_ERR,
    output logic RUNT_ERR,
    output logic [15:0] PKT_COUNT,
    output logic [15:0] BAD_COUNT
);
    import eth_tx_stream_pkg::*;

    // the core clock is the link clock and goes out unchanged; it must be
    // built at TXMAC_FREQ_HZ in a chip, the default CORE_CLK rate is for bench use
    assign bus.clk_txmac = CORE_CLK;

    logic req;
    logic in_pkt;
    logic [COUNT_W-1:0] count;
    logic next_in_pkt;
    logic [COUNT_W-1:0] next_count;
    logic next_gap;
    logic next_sop_err;
    logic next_runt;
    logic [LANES-1:0] next_bad;
    logic [LANES-1:0] next_word;
    logic [2:0] next_ends;

    // accept comes from a flop; a beat is taken in every cycle it is high
    assign bus.din_req = req;
    wire take = req;

    // per-word decode of the incoming beat
    wire [LANES-1:0] frame_word = ~bus.din_idle;
    wire [3:0] lane_bytes [LANES];
    wire [BUS_W-1:0] marked_data;

    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            // empty bytes drop off the low end of the end word
            assign lane_bytes[g] = bus.din_eop[g] ?
                4'(BYTES_PER_WORD - {1'b0, empty_of(bus.din_eop_empty, g)}) :
                BYTES_PER_WORD;
            // corruption hits a byte that is always valid so the checksum breaks
            assign marked_data[g*WORD_W +: WORD_W] = next_bad[g] ?
                (word_of(bus.din, g) ^ CORRUPT_MASK) : word_of(bus.din, g);
        end
    endgenerate

    // walk the four words from the top down, since the top word leaves first
    always_comb
    begin
        next_in_pkt = in_pkt;
        next_count = count;
        next_gap = 1'b0;
        next_sop_err = 1'b0;
        next_runt = 1'b0;
        next_bad = FLAGS_NONE;
        next_word = FLAGS_NONE;
        next_ends = 3'h0;
        if (take)
        begin
            for (int i = LANES - 1; i >= 0; i--)
            begin
                if (!frame_word[i])
                begin
                    // an idle word inside a packet is a gap the link cannot carry
                    if (next_in_pkt)
                    begin
                        next_gap = 1'b1;
                    end
                end
                else
                begin
                    if (bus.din_sop[i])
                    begin
                        // a new start before the old packet ended
                        if (next_in_pkt)
                        begin
                            next_sop_err = 1'b1;
                        end
                        next_in_pkt = 1'b1;
                        next_count = '0;
                    end
                    // words outside a packet are not considered
                    if (next_in_pkt)
                    begin
                        next_word[i] = 1'b1;
                        // count saturates once the minimum length is reached
                        if (next_count < MIN_FRAME_BYTES)
                        begin
                            next_count = COUNT_W'(next_count + {1'b0, lane_bytes[i]});
                        end
                        if (bus.din_eop[i])
                        begin
                            if (next_count < MIN_FRAME_BYTES)
                            begin
                                next_runt = 1'b1;
                            end
                            next_bad[i] = bus.tx_error[i] && (bus.din_eop != FLAGS_NONE);
                            next_ends = 3'(next_ends + 3'h1);
                            next_in_pkt = 1'b0;
                        end
                    end
                end
            end
        end
    end

    // count packets and corrupted packets seen
    wire [2:0] bad_ends = 3'({2'h0, next_bad[0]} + {2'h0, next_bad[1]}
                             + {2'h0, next_bad[2]} + {2'h0, next_bad[3]});

    // packet tracking and the accept; accept follows the drain side one cycle late
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            req <= 1'b0;
            in_pkt <= 1'b0;
            count <= '0;
            PKT_COUNT <= 16'h0000;
            BAD_COUNT <= 16'h0000;
        end
        else
        begin
            req <= DRAIN_READY;
            in_pkt <= next_in_pkt;
            count <= next_count;
            PKT_COUNT <= 16'(PKT_COUNT + {13'h0, next_ends});
            BAD_COUNT <= 16'(BAD_COUNT + {13'h0, bad_ends});
        end
    end

    // forwarded words, one cycle after they were taken
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            OUT_VALID <= 1'b0;
            OUT_DATA <= '0;
            OUT_SOP <= FLAGS_NONE;
            OUT_EOP <= FLAGS_NONE;
            OUT_EMPTY <= '0;
            OUT_DATA_WORD <= FLAGS_NONE;
            OUT_BAD <= FLAGS_NONE;
        end
        else
        begin
            OUT_VALID <= take;
            OUT_DATA <= take ? marked_data : '0;
            OUT_SOP <= take ? (bus.din_sop & frame_word) : FLAGS_NONE;
            OUT_EOP <= take ? (bus.din_eop & next_word) : FLAGS_NONE;
            OUT_EMPTY <= take ? bus.din_eop_empty : '0;
            OUT_DATA_WORD <= next_word;
            OUT_BAD <= next_bad;
        end
    end

    // framing faults are one-cycle pulses aligned with the forwarded beat
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            GAP_ERR <= 1'b0;
            SOP_ERR <= 1'b0;
            RUNT_ERR <= 1'b0;
        end
        else
        begin
            GAP_ERR <= next_gap;
            SOP_ERR <= next_sop_err;
            RUNT_ERR <= next_runt;
        end
    end
endmodule

//--- common/eth_tx_stream_pkg.sv
// shared constants, word layout and decode helpers for the tx client word stream
package eth_tx_stream_pkg;

    // bus geometry
    localparam int LANES = 4;
    localparam int WORD_W = 64;
    localparam int BUS_W = LANES * WORD_W;
    localparam int EMPTY_W = 3;
    localparam int EMPTY_BUS_W = LANES * EMPTY_W;
    localparam int LANE_W = 2;

    // a full word carries eight frame bytes
    localparam logic [3:0] BYTES_PER_WORD = 4'h8;

    // shortest frame the mac handles correctly
    localparam logic [4:0] MIN_FRAME_BYTES = 5'h09;
    localparam int COUNT_W = 5;

    // link clock rate; the core clock must be built to this in a real chip
    localparam int TXMAC_FREQ_HZ = 390625000;
    localparam int CORE_CLK_HZ = 100000000;

    // reset and idle values of the client drive
    localparam logic [3:0] IDLE_ALL = 4'hF;
    localparam logic [3:0] FLAGS_NONE = 4'h0;
    localparam logic [EMPTY_W-1:0] EMPTY_NONE = 3'h0;

    // injected errors flip the top byte, which is always a valid byte of the word
    localparam logic [WORD_W-1:0] CORRUPT_MASK = 64'hFF00_0000_0000_0000;

    // depth of the client hand-off store
    localparam int CLIENT_SLOTS = 2;
    localparam logic [1:0] SLOTS_FULL = 2'h2;

    // one bus beat as the client holds it
    typedef struct packed {
        logic [BUS_W-1:0] data;
        logic [LANES-1:0] sop;
        logic [LANES-1:0] eop;
        logic [EMPTY_BUS_W-1:0] empty;
        logic [LANES-1:0] idle;
        logic [LANES-1:0] error;
    } beat_s;

    // empty-count slice of word z sits at bits [3z+2:3z]
    function automatic logic [EMPTY_W-1:0] empty_of(input logic [EMPTY_BUS_W-1:0] vec,
                                                     input int lane);
        empty_of = vec[lane*EMPTY_W +: EMPTY_W];
    endfunction

    // 64-bit word z sits at bits [64z+63:64z]
    function automatic logic [WORD_W-1:0] word_of(input logic [BUS_W-1:0] vec,
                                                  input int lane);
        word_of = vec[lane*WORD_W +: WORD_W];
    endfunction

endpackage

//--- common/eth_tx_stream_if.sv
// interface joining the client end and the mac end of the tx word stream
`timescale 1ns/1ps
interface eth_tx_stream_if;
    import eth_tx_stream_pkg::*;

    logic clk_txmac;
    logic [BUS_W-1:0] din;
    logic [LANES-1:0] din_sop;
    logic [LANES-1:0] din_eop;
    logic [EMPTY_BUS_W-1:0] din_eop_empty;
    logic [LANES-1:0] din_idle;
    logic [LANES-1:0] tx_error;
    logic din_req;

    // the mac end makes the clock and the accept
    modport mac (
        output clk_txmac,
        output din_req,
        input din,
        input din_sop,
        input din_eop,
        input din_eop_empty,
        input din_idle,
        input tx_error
    );

    // the client end drives the beat on the mac's clock
    modport client (
        input clk_txmac,
        input din_req,
        output din,
        output din_sop,
        output din_eop,
        output din_eop_empty,
        output din_idle,
        output tx_error
    );
endinterface

//--- verilog/eth_tx_client_end.sv
// client end: two-slot hand-off that feeds user beats onto the tx word stream
`timescale 1ns/1ps
module eth_tx_client_end (
    input wire logic RST_N,
    eth_tx_stream_if.client bus,
    input wire logic USER_VALID,
    output logic USER_READY,
    input wire logic [eth_tx_stream_pkg::BUS_W-1:0] USER_DATA,
    input wire logic [eth_tx_stream_pkg::LANES-1:0] USER_SOP,
    input wire logic [eth_tx_stream_pkg::LANES-1:0] USER_EOP,
    input wire logic [eth_tx_stream_pkg::EMPTY_BUS_W-1:0] USER_EMPTY,
    input wire logic [eth_tx_stream_pkg::LANES-1:0] USER_IDLE,
    input wire logic [eth_tx_stream_pkg::LANES-1:0] USER_ERROR
);
    import eth_tx_stream_pkg::*;

    // everything here runs on the clock the mac hands out
    wire clk;
    assign clk = bus.clk_txmac;

    beat_s slot [CLIENT_SLOTS];
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] used;
    logic [1:0] next_used;
    beat_s in_beat;
    beat_s head;

    wire push = USER_VALID && USER_READY;
    wire pop = bus.din_req && (used != 2'h0);

    // user bus is already big-endian: word 3 is the top 64 bits
    assign in_beat.data = USER_DATA;
    assign in_beat.sop = USER_SOP;
    assign in_beat.eop = USER_EOP;
    assign in_beat.idle = USER_IDLE;
    // error only counts on words that end a packet
    assign in_beat.error = USER_ERROR & USER_EOP;

    // empty counts are cleared on words that do not end a packet
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_empty
            assign in_beat.empty[g*EMPTY_W +: EMPTY_W] =
                USER_EOP[g] ? empty_of(USER_EMPTY, g) : EMPTY_NONE;
        end
    endgenerate

    assign next_used = 2'(used + {1'b0, push} - {1'b0, pop});
    assign head = slot[rd_ptr];

    // the head beat stays on the bus until the mac accepts it
    assign bus.din = (used != 2'h0) ? head.data : '0;
    assign bus.din_sop = (used != 2'h0) ? head.sop : FLAGS_NONE;
    assign bus.din_eop = (used != 2'h0) ? head.eop : FLAGS_NONE;
    assign bus.din_eop_empty = (used != 2'h0) ? head.empty : '0;
    // nothing queued: mark every word idle so the mac sees no frame data
    assign bus.din_idle = (used != 2'h0) ? head.idle : IDLE_ALL;
    assign bus.tx_error = (used != 2'h0) ? head.error : FLAGS_NONE;

    // two slots let a beat enter while one leaves, so a packet streams gap-free
    always_ff @(posedge clk)
    begin
        if (!RST_N)
        begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            used <= 2'h0;
            USER_READY <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                slot[wr_ptr] <= in_beat;
            end
            wr_ptr <= wr_ptr ^ push;
            rd_ptr <= rd_ptr ^ pop;
            used <= next_used;
            USER_READY <= (next_used != SLOTS_FULL);
        end
    end
endmodule

//--- verif/eth_tx_stream_assertions.sv
// concurrent checks on the tx word stream between the two ends
`timescale 1ns/1ps
module eth_tx_stream_assertions (
    input wire logic clk_txmac,
    input wire logic RST_N,
    input wire logic [255:0] din,
    input wire logic [3:0] din_sop,
    input wire logic [3:0] din_eop,
    input wire logic [11:0] din_eop_empty,
    input wire logic [3:0] din_idle,
    input wire logic [3:0] tx_error,
    input wire logic din_req
);
    default clocking cb @(posedge clk_txmac); endclocking
    default disable iff (!RST_N);
    // a real beat waits on the bus while the mac holds off
    wire logic held = !din_req && din_idle != 4'hF;
    // end flags spread over their three-bit empty slices
    wire logic [11:0] eop_w = {{3{din_eop[3]}}, {3{din_eop[2]}}, {3{din_eop[1]}},
        {3{din_eop[0]}}};

    property p_hold_d; held |=> $stable(din) && $stable(din_sop) && $stable(din_eop); endproperty
    a_hold_d: assert property (p_hold_d) else $error("beat moved");
    property p_hold_f; held |=> $stable({din_eop_empty, din_idle, tx_error}); endproperty
    a_hold_f: assert property (p_hold_f) else $error("flags moved");
    property p_err_mask; (tx_error & ~din_eop) == 4'h0; endproperty
    a_err_mask: assert property (p_err_mask) else $error("stray error");
    property p_empty_clr; (din_eop_empty & ~eop_w) == 12'h000; endproperty
    a_empty_clr: assert property (p_empty_clr) else $error("stray empty");
    property p_fill; din_idle == 4'hF |-> (din_sop | din_eop | tx_error) == 4'h0; endproperty
    a_fill: assert property (p_fill) else $error("bad fill");
    property p_rst_bus; disable iff (1'b0) !RST_N |=> din_idle == 4'hF && !din_req; endproperty
    a_rst_bus: assert property (p_rst_bus) else $error("reset bus");
    property p_rst_req; $rose(RST_N) |-> !din_req; endproperty
    a_rst_req: assert property (p_rst_req) else $error("early accept");
    property p_accept; din_idle != 4'hF |-> ##[0:40] din_req; endproperty
    a_accept: assert property (p_accept) else $error("beat never taken");

    c_sop: cover property (din_req && din_sop != 4'h0);
    c_err: cover property (din_req && (tx_error & din_eop) != 4'h0);
    c_stall: cover property (held ##1 din_req);
endmodule

//--- verif/testbench.sv
// self-checking bench: client end feeds the mac end
`timescale 1ns/1ps
module testbench;
    import eth_tx_stream_pkg::*;
    localparam int W = $bits(beat_s);
    logic CORE_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic drain = 1'b0;
    logic user_valid = 1'b0;
    logic user_ready, out_valid, gap_err, sop_err, runt_err;
    logic e_valid = 1'b0;
    logic e_pkt = 1'b0;
    logic in_pkt = 1'b0;
    logic has_idle = 1'b0;
    // expected {gap, second start, runt} pulses of the beat taken last
    logic [2:0] e_flags = 3'h0;
    int n_bytes = 0;
    logic [15:0] pkt_count, bad_count;
    beat_s ub = '0;
    beat_s cur = '0;
    beat_s e;
    beat_s q[$];
    wire beat_s ob;
    int lane = 3;
    int n_pkt = 0;
    int n_bad = 0;
    int num_errors = 0;
    int n_compared = 0;

    eth_tx_stream_if bus();
    eth_tx_client_end u_eth_tx_client_end (.RST_N(RST_N), .bus(bus), .USER_VALID(user_valid),
        .USER_READY(user_ready), .USER_DATA(ub.data), .USER_SOP(ub.sop), .USER_EOP(ub.eop),
        .USER_EMPTY(ub.empty), .USER_IDLE(ub.idle), .USER_ERROR(ub.error));
    eth_tx_mac_end u_eth_tx_mac_end (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .bus(bus),
        .DRAIN_READY(drain), .OUT_VALID(out_valid), .OUT_DATA(ob.data), .OUT_SOP(ob.sop),
        .OUT_EOP(ob.eop), .OUT_EMPTY(ob.empty), .OUT_DATA_WORD(ob.idle), .OUT_BAD(ob.error),
        .GAP_ERR(gap_err), .SOP_ERR(sop_err), .RUNT_ERR(runt_err), .PKT_COUNT(pkt_count),
        .BAD_COUNT(bad_count));
    eth_tx_stream_assertions u_eth_tx_stream_assertions (.clk_txmac(bus.clk_txmac),
        .RST_N(RST_N), .din(bus.din), .din_sop(bus.din_sop), .din_eop(bus.din_eop),
        .din_eop_empty(bus.din_eop_empty), .din_idle(bus.din_idle), .tx_error(bus.tx_error),
        .din_req(bus.din_req));

    always #5 CORE_CLK = ~CORE_CLK;

    task automatic chk(input string n, input logic [W-1:0] x, input logic [W-1:0] y);
        n_compared++;
        if (x !== y)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, x, y);
        end
    endtask

    task automatic stop_test;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // offer a beat; the client cleans empty and error off non-end words
    task automatic send(input beat_s b);
        while (user_ready !== 1'b1)
            @(negedge CORE_CLK);
        ub = b;
        user_valid = 1'b1;
        for (int z = 0; z < LANES; z++)
            if (!b.eop[z])
                b.empty[z*3 +: 3] = 3'h0;
        b.error &= b.eop;
        q.push_back(b);
        @(negedge CORE_CLK);
    endtask

    // fill lanes top first; junk empty and error ride on non-end words
    task automatic put_word(input logic s, f, r, idl, input logic [2:0] m);
        cur.data[lane*64 +: 64] = {$urandom, $urandom};
        cur.sop[lane] = s;
        cur.eop[lane] = f;
        cur.error[lane] = r;
        cur.idle[lane] = idl;
        cur.empty[lane*3 +: 3] = m;
        has_idle |= idl;
        lane--;
        if (lane < 0)
        begin
            send(cur);
            cur = '0;
            has_idle = 1'b0;
            lane = 3;
        end
    endtask

    // packets of two words or more always hold nine bytes or more
    task automatic pkt(input int n, input logic [2:0] m);
        logic r;
        r = $urandom_range(3) == 0;
        for (int i = 0; i < n; i++)
            put_word(i == 0, i == n - 1, r, 1'b0, m);
        if ($urandom_range(1) == 1)
            put_word(1'b0, 1'b0, r, !has_idle, m);
    endtask

    // mac view: idle marks packet words, error marks corrupted ends
    function automatic beat_s expect_beat(input beat_s b);
        beat_s o;
        o = '0;
        o.data = b.data;
        o.empty = b.empty;
        o.sop = b.sop & ~b.idle;
        e_flags = 3'h0;
        for (int z = 3; z >= 0; z--)
        begin
            // an idle word inside a packet is a gap; a start inside one restarts it
            e_flags[2] |= b.idle[z] && in_pkt;
            if (!b.idle[z] && b.sop[z])
            begin
                e_flags[1] |= in_pkt;
                in_pkt = 1'b1;
                n_bytes = 0;
            end
            if (!b.idle[z] && in_pkt)
            begin
                o.idle[z] = 1'b1;
                n_bytes += int'(BYTES_PER_WORD);
                if (b.eop[z])
                begin
                    // empty bytes come off the end word; short frames are flagged
                    n_bytes -= int'(b.empty[z*3 +: 3]);
                    e_flags[0] |= n_bytes < int'(MIN_FRAME_BYTES);
                    o.eop[z] = 1'b1;
                    o.error[z] = b.error[z];
                    if (b.error[z])
                        o.data[z*64 +: 64] ^= CORRUPT_MASK;
                    n_pkt++;
                    n_bad += int'(b.error[z]);
                    in_pkt = 1'b0;
                end
            end
        end
        return o;
    endfunction

    // stalls downstream now and then; checks bus and mac result
    always @(negedge CORE_CLK)
    begin
        drain = $urandom_range(3) != 0;
        chk("valid", W'(e_valid), W'(out_valid));
        if (e_pkt)
        begin
            chk("out", e, ob);
            chk("flags", W'(e_flags), W'({gap_err, sop_err, runt_err}));
        end
        e_valid = bus.din_req;
        e_pkt = 1'b0;
        if (bus.din_req && bus.din_idle !== IDLE_ALL && q.size() > 0)
        begin
            chk("din", q[0], {bus.din, bus.din_sop, bus.din_eop,
                bus.din_eop_empty, bus.din_idle, bus.tx_error});
            e = expect_beat(q.pop_front());
            e_pkt = 1'b1;
        end
    end

    // reset, framing faults the mac must flag, a nine-byte packet, then random packets
    initial
    begin
        void'($urandom(36));
        repeat (10) @(negedge CORE_CLK);
        RST_N = 1'b1;
        @(negedge CORE_CLK);
        // first beat: start, idle gap, second start, end with error; then a runt
        put_word(1'b1, 1'b0, 1'b0, 1'b0, 3'h0);
        put_word(1'b0, 1'b0, 1'b0, 1'b1, 3'h0);
        put_word(1'b1, 1'b0, 1'b0, 1'b0, 3'h0);
        put_word(1'b0, 1'b1, 1'b1, 1'b0, 3'h2);
        pkt(1, 3'h2);
        pkt(2, 3'h7);
        for (int i = 0; i < 60; i++)
            pkt(2 + $urandom_range(7), 3'($urandom_range(7)));
        while (lane != 3)
            put_word(1'b0, 1'b0, 1'b0, !has_idle, 3'h0);
        user_valid = 1'b0;
        for (int i = 0; i < 60 && q.size() > 0; i++)
            @(negedge CORE_CLK);
        repeat (2) @(negedge CORE_CLK);
        chk("left", W'(0), W'(q.size()));
        chk("pkts", W'(n_pkt), W'(pkt_count));
        chk("bad", W'(n_bad), W'(bad_count));
        stop_test();
    end

    // watchdog well beyond the expected run of under two hundred cycles
    initial
    begin
        repeat (5000) @(posedge CORE_CLK);
        num_errors++;
        stop_test();
    end
endmodule
